/* File: inc/fsq_pkg.sv */
// constants and types for the serial flash command sequencer
// assumes a 40 MHz core clock and a host-made serial clock
package fsq_pkg;
  typedef logic [23:0] fsq_addr_t;
  typedef logic [7:0]  fsq_byte_t;
  // ==========================================
  // opcodes
  localparam fsq_byte_t OP_WRAP = 8'h77;
  localparam fsq_byte_t OP_QWRD = 8'hE7;
  localparam fsq_byte_t OP_QRD  = 8'hEB;
  localparam fsq_byte_t OP_DISCOVERABLE_PARAMETERS = 8'h5A;
  localparam fsq_byte_t OP_PP   = 8'h02;
  localparam fsq_byte_t OP_WREN = 8'h06;
  localparam fsq_byte_t OP_RDSR = 8'h05;
  localparam fsq_byte_t OP_CRMR = 8'hFF;
  // ==========================================
  // fields and reset values
  localparam int        WRAP_DIS_POS = 0;
  localparam int        STAT_BSY_POS = 0;
  localparam int        STAT_WEL_POS = 1;
  localparam logic [2:0] WRAP_RST    = 3'h1;
  localparam logic       QE_RST      = 1'b1;
  localparam logic [1:0] CONT_ON     = 2'h2;
  localparam fsq_byte_t  ERASED      = 8'hFF;
  // phase lengths in serial clock rising edges
  localparam logic [5:0] LEN_OPC  = 6'h08;
  localparam logic [5:0] LEN_AQ   = 6'h06;
  localparam logic [5:0] LEN_AS   = 6'h18;
  localparam logic [5:0] LEN_MODE = 6'h02;
  localparam logic [5:0] LEN_DQW  = 6'h02;
  localparam logic [5:0] LEN_DQ   = 6'h04;
  localparam logic [5:0] LEN_DSF  = 6'h08;
  localparam logic [5:0] LEN_WRAP = 6'h20;
  // parameter table, 8 bytes, beyond reads erased
  localparam logic [63:0] DISCOVERABLE_PARAMETERS_TBL = 64'h5346_4450_0601_00FF;
  // ==========================================
  // timing
  localparam int CLK_MHZ       = 40;
  localparam int PROG_TIME_US  = 3000;
  localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
endpackage : fsq_pkg

/* File: inc/fsq_if.sv */
// carriers between the sequencer and its buffers
// assumes all users sit on one core clock
`timescale 1ns/1ps
// ==========================================
// byte stream with valid and ready
interface fsq_strm_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fsq_strm_if
// ==========================================
// page buffer ports
interface fsq_pbuf_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : fsq_pbuf_if

/* File: hdl/fsq_fifo2.sv */
// two-entry byte buffer between array fetch and shifter
// assumes push and pop on the core clock; flush wins
`timescale 1ns/1ps
module fsq_fifo2 (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_flush,
  fsq_strm_if.snk   wr,
  fsq_strm_if.src   rd
);
  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] n;
  } fsq_f_t;
  fsq_f_t q;
  fsq_f_t d;
  logic   push;
  logic   pop;
  // ready falls when full so the fetcher stalls
  assign wr.ready = (q.n != 2'h2);
  assign rd.valid = (q.n != 2'h0);
  assign rd.data  = q.d0;
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;
  // ==========================================
  always_comb begin
    d = q;
    if (pop) begin
      d.d0 = q.d1;
      d.n  = q.n - 2'h1;
    end
    if (push) begin
      if (d.n == 2'h0) d.d0 = wr.data;
      else d.d1 = wr.data;
      d.n = d.n + 2'h1;
    end
    if (i_flush) d.n = 2'h0;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= d;
  end
endmodule : fsq_fifo2

/* File: hdl/fsq_page_mem.sv */
// 256-byte page buffer, registered read
// assumes one writer and one reader on the core clock
`timescale 1ns/1ps
module fsq_page_mem (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  fsq_pbuf_if.mem   pb
);
  import fsq_pkg::*;
  typedef struct packed {
    logic [255:0][7:0] m;
    logic [7:0]        rd;
  } fsq_m_t;
  fsq_m_t q;
  fsq_m_t d;
  assign pb.rdata = q.rd;
  // ==========================================
  always_comb begin
    d = q;
    if (pb.we) d.m[pb.waddr] = pb.wdata;
    d.rd = q.m[pb.raddr];
  end
  // erased pattern at reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= {{256{ERASED}}, ERASED};
    else q <= d;
  end
endmodule : fsq_page_mem

/* File: hdl/fsq_flash_seq.sv */
// serial flash command sequencer: wrap, quad reads, table read, program
// assumes host drives cs, serial clock 5 MHz max, array answers next clk
// Operation
// - 77h, 24 dummy bits, wrap byte captured
// - wrap on when disable bit 0; length 8/16/32/64 bytes
// - wrap setting applies to later quad reads in any page
// - wrap off after reset; another 77h with disable bit 1 turns it off
// - wrapped read loops inside aligned section until cs rises
// - E7h: host gives even address; two dummy clocks
// - read address steps by one per byte sent
// - quad reads need quad enable, set after reset
// - mode bits 10 let next access skip the opcode
// - continuous mode reset opcode clears the mode bits
// - 5Ah returns the parameter table
// - 02h programs 1..256 bytes only with write enable latch set
// - erased byte is FFh; unsupplied bytes stay erased
// - three address bytes, then data into page buffer
// - data past page end wraps to page start
// - over 256 bytes keeps the last 256
// - cs rise starts the timed write of buffered bytes
// - needs full address, one byte, byte boundary, else abort
// - protected target: no program, back to idle
// - aborts clear the write enable latch
// - busy during program; latch cleared before the end
// - busy flag 1 while programming, 0 when done
`timescale 1ns/1ps
module fsq_flash_seq #(
  parameter int P_PROG_CYCLES = fsq_pkg::PROG_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_cs_n,
  input  wire logic              i_sck,
  input  wire logic [3:0]        i_io,
  input  wire logic              i_protected,
  input  wire logic              i_qe_load,
  input  wire logic              i_qe_value,
  input  wire fsq_pkg::fsq_byte_t i_arr_rdata,
  output logic [3:0]             o_io,
  output logic [3:0]             o_io_oe,
  output fsq_pkg::fsq_addr_t     o_arr_addr,
  output logic                   o_arr_rd,
  output logic                   o_arr_wr,
  output fsq_pkg::fsq_byte_t     o_arr_wdata,
  output logic                   o_busy,
  output logic                   o_wel,
  output logic                   o_quad_enable,
  output logic [2:0]             o_wrap_setting,
  output logic                   o_cont_mode
);
  import fsq_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_WRAP, S_PGM
  } fsq_lnk_t;
  typedef enum logic [1:0] {P_IDLE, P_WRITE, P_WAIT} fsq_pg_t;
  typedef struct packed {
    logic [5:0]   sy1;
    logic [5:0]   sy2;
    logic [5:0]   sy3;
    fsq_lnk_t     st;
    logic         ign;
    fsq_byte_t    op;
    logic [5:0]   ph;
    logic [23:0]  sr;
    logic [2:0]   b3;
    logic         gotb;
    fsq_addr_t    pst;
    logic [7:0]   pidx;
    logic [255:0] vld;
    logic [2:0]   wrap;
    logic         qe;
    logic         write_enable_latch;
    logic         cont;
    fsq_byte_t    cop;
    fsq_addr_t    fa;
    logic         fe;
    logic         pend;
    fsq_byte_t    sh;
    logic [2:0]   bl;
    logic [3:0]   io;
    logic [3:0]   oe;
    fsq_pg_t      pg;
    logic [8:0]   pc;
    logic [23:0]  tmr;
    fsq_addr_t    aa;
    logic         ard;
    logic         awr;
    fsq_byte_t    awd;
  } fsq_st_t;
  localparam fsq_st_t ST_RST = '{sy1: '1, sy2: '1, sy3: '1, st: S_IDLE,
    pg: P_IDLE, wrap: WRAP_RST, qe: QE_RST, default: '0};
  fsq_st_t    q;
  fsq_st_t    d;
  logic       cs_rise;
  logic       cs_fall;
  logic       sk_rise;
  logic       sk_fall;
  logic       quad;
  logic       wrap_on;
  logic [7:0] msk;
  logic       pp_ok;
  logic [3:0] pin;
  fsq_byte_t  stat;
  fsq_byte_t  discoverable_parameters_b;
  fsq_strm_if u_fin ();
  fsq_strm_if u_fout ();
  fsq_pbuf_if u_pb ();
  // ==========================================
  // edges of the synchronised pins
  assign pin     = q.sy2[3:0];
  assign cs_rise = q.sy2[5] && !q.sy3[5];
  assign cs_fall = !q.sy2[5] && q.sy3[5];
  assign sk_rise = !q.sy2[5] && q.sy2[4] && !q.sy3[4];
  assign sk_fall = !q.sy2[5] && !q.sy2[4] && q.sy3[4];
  // wrap only for the two quad reads
  assign quad    = (q.op == OP_QWRD) || (q.op == OP_QRD);
  assign wrap_on = quad && !q.wrap[WRAP_DIS_POS];
  assign msk     = 8'((8'h08 << q.wrap[2:1]) - 8'h01);
  // program accepted only when whole, enabled and unprotected
  assign pp_ok   = q.gotb && (q.b3 == 3'h0) && q.write_enable_latch && !i_protected;
  // ==========================================
  // byte sources besides the array
  always_comb begin
    stat = 8'h00;
    stat[STAT_BSY_POS] = (q.pg != P_IDLE);
    stat[STAT_WEL_POS] = q.write_enable_latch;
    discoverable_parameters_b = (q.aa[23:3] == 21'h00_0000) ? DISCOVERABLE_PARAMETERS_TBL[8'(63 - 8 * q.aa[2:0]) -: 8]
                                         : ERASED;
  end
  // push one cycle after the fetch, array data is valid then
  assign u_fin.valid  = q.pend;
  assign u_fin.data   = (q.op == OP_RDSR) ? stat :
                        (q.op == OP_DISCOVERABLE_PARAMETERS) ? discoverable_parameters_b : i_arr_rdata;
  assign u_fout.ready = sk_fall && (q.st == S_DATA) && (q.bl == 3'h0);
  // page buffer fill from the link, drain by the program engine
  assign u_pb.we      = sk_rise && (q.st == S_PGM) && !q.ign && (q.b3 == 3'h7);
  assign u_pb.waddr   = q.pidx;
  assign u_pb.wdata   = {q.sr[6:0], pin[0]};
  assign u_pb.raddr   = q.pc[8:1];
  // ==========================================
  always_comb begin
    d     = q;
    d.sy1 = {i_cs_n, i_sck, i_io};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    d.ard = 1'b0;
    d.awr = 1'b0;
    d.pend = 1'b0;
    if (i_qe_load) d.qe = i_qe_value;
    // fetch ahead while the buffer has room
    if (q.fe && u_fin.ready && !q.pend) begin
      d.pend = 1'b1;
      d.ard  = quad;
      d.aa   = q.fa;
      if (q.op != OP_RDSR) begin
        d.fa = wrap_on ? {q.fa[23:8], (q.fa[7:0] & ~msk) | (8'(q.fa[7:0] + 8'h01) & msk)}
                       : 24'(q.fa + 24'h00_0001);
      end
    end
    // command boundary
    if (cs_rise) begin
      d.st   = S_IDLE;
      d.fe   = 1'b0;
      d.pend = 1'b0;
      d.oe   = 4'h0;
      d.ard  = 1'b0;
      if (!q.ign && q.op == OP_WREN && q.st == S_IDLE && q.b3 == 3'h0) d.write_enable_latch = 1'b1;
      if (!q.ign && q.op == OP_PP && q.st != S_OPC) begin
        if (q.st == S_PGM && pp_ok) begin
          d.pg = P_WRITE;
          d.pc = 9'h000;
        end else begin
          d.write_enable_latch = 1'b0;
        end
      end
    end else if (cs_fall) begin
      d.b3   = 3'h0;
      d.gotb = 1'b0;
      d.sr   = 24'h00_0000;
      d.ign  = 1'b0;
      if (q.cont && q.pg == P_IDLE) begin
        d.st = S_ADDR;
        d.op = q.cop;
        d.ph = LEN_AQ;
        d.ign = !q.qe;
      end else begin
        d.st = S_OPC;
        d.op = 8'h00;
        d.ph = LEN_OPC;
      end
    end else if (sk_rise) begin
      d.b3 = q.b3 + 3'h1;
      d.ph = q.ph - 6'h01;
      d.sr = quad && q.st != S_OPC ? {q.sr[19:0], pin} : {q.sr[22:0], pin[0]};
      unique case (q.st)
        S_OPC: if (q.ph == 6'h01) begin
          d.op = {q.sr[6:0], pin[0]};
          d.st = S_IDLE;
          if (q.pg != P_IDLE && d.op != OP_RDSR) d.ign = 1'b1;
          else unique case (d.op)
            OP_QWRD, OP_QRD: begin
              d.ign = !q.qe;
              d.st  = S_ADDR;
              d.ph  = LEN_AQ;
            end
            OP_DISCOVERABLE_PARAMETERS, OP_PP: begin
              d.st  = S_ADDR;
              d.ph  = LEN_AS;
              d.vld = '0;
            end
            OP_WRAP: begin
              d.st = S_WRAP;
              d.ph = LEN_WRAP;
            end
            OP_RDSR: begin
              d.st = S_DATA;
              d.fe = 1'b1;
              d.bl = 3'h0;
            end
            OP_CRMR: d.cont = 1'b0;
            default: d.ign = (d.op != OP_WREN);
          endcase
        end
        S_ADDR: if (q.ph == 6'h01 && !q.ign) begin
          if (q.op == OP_PP) begin
            d.pst  = d.sr;
            d.pidx = d.sr[7:0];
            d.st   = S_PGM;
          end else begin
            d.fa = d.sr;
            d.fe = 1'b1;
            d.st = quad ? S_MODE : S_DUMMY;
            d.ph = quad ? LEN_MODE : LEN_DSF;
          end
        end
        S_MODE: if (q.ph == 6'h01) begin
          d.cont = (d.sr[5:4] == CONT_ON);
          d.cop  = q.op;
          d.st   = S_DUMMY;
          d.ph   = (q.op == OP_QWRD) ? LEN_DQW : LEN_DQ;
        end
        S_DUMMY: if (q.ph == 6'h01) begin
          d.st = S_DATA;
          d.bl = 3'h0;
        end
        S_WRAP: if (q.ph == 6'h01) begin
          d.wrap = q.sr[5:3];
          d.st   = S_IDLE;
        end
        S_PGM: if (q.b3 == 3'h7 && !q.ign) begin
          d.gotb         = 1'b1;
          d.vld[q.pidx]  = 1'b1;
          d.pidx         = q.pidx + 8'h01;
        end
        default: d.ph = q.ph;
      endcase
    end else if (sk_fall && q.st == S_DATA) begin
      // new bits on the falling edge, host samples on the rising one
      if (q.bl == 3'h0) begin
        d.sh = u_fout.valid ? u_fout.data : ERASED;
        d.bl = quad ? 3'h1 : 3'h7;
      end else begin
        d.sh = q.sh;
        d.bl = q.bl - 3'h1;
      end
      d.io = quad ? d.sh[7:4] : {2'b00, d.sh[7], 1'b0};
      d.oe = quad ? 4'hF : 4'h2;
      d.sh = quad ? {d.sh[3:0], 4'h0} : {d.sh[6:0], 1'b0};
    end
    // ==========================================
    // self-timed program: even cycle reads buffer, odd writes array
    unique case (q.pg)
      P_IDLE: ;
      P_WRITE: begin
        if (q.pc[0] && q.vld[q.pc[8:1]]) begin
          d.awr = 1'b1;
          d.aa  = {q.pst[23:8], q.pc[8:1]};
          d.awd = u_pb.rdata;
        end
        d.pc = q.pc + 9'h001;
        if (q.pc == 9'h1FF) begin
          d.pg  = P_WAIT;
          d.tmr = 24'(P_PROG_CYCLES);
          d.write_enable_latch = 1'b0;
        end
      end
      P_WAIT: begin
        d.tmr = q.tmr - 24'h00_0001;
        if (q.tmr <= 24'h00_0001) d.pg = P_IDLE;
      end
      default: d.pg = P_IDLE;
    endcase
  end
  // ==========================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= ST_RST;
    else q <= d;
  end
  // ==========================================
  // buffers
  fsq_fifo2 u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_flush (cs_rise),
    .wr      (u_fin.snk),
    .rd      (u_fout.src)
  );
  fsq_page_mem u_pmem (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .pb      (u_pb.mem)
  );
  // outputs straight from state flops
  assign o_io           = q.io;
  assign o_io_oe        = q.oe;
  assign o_arr_addr     = q.aa;
  assign o_arr_rd       = q.ard;
  assign o_arr_wr       = q.awr;
  assign o_arr_wdata    = q.awd;
  assign o_busy         = (q.pg != P_IDLE);
  assign o_wel          = q.write_enable_latch;
  assign o_quad_enable  = q.qe;
  assign o_wrap_setting = q.wrap;
  assign o_cont_mode    = q.cont;
  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wrap_capture_a: assert property ($changed(q.wrap) |-> $past(q.st) == S_WRAP)
    else $error("wrap setting changed outside wrap command");
  wrap_section_a: assert property (q.ard && wrap_on |->
    (q.fa[7:0] & ~msk) == (q.aa[7:0] & ~msk) && q.fa[23:8] == q.aa[23:8])
    else $error("wrapped read left its section");
  read_step_a: assert property (q.ard && !wrap_on |-> q.fa == 24'(q.aa + 24'h00_0001))
    else $error("read address did not step by one");
  qe_gate_a: assert property (q.st == S_ADDR && !q.ign && quad |-> q.qe)
    else $error("quad read accepted without quad enable");
  cont_skip_a: assert property (cs_fall && q.cont && q.pg == P_IDLE |=>
    q.st == S_ADDR && q.op == $past(q.cop))
    else $error("continuous mode did not skip opcode");
  prog_start_a: assert property (q.pg == P_WRITE && $past(q.pg) == P_IDLE |->
    $past(q.write_enable_latch) && $past(q.gotb) && $past(q.b3) == 3'h0 && !$past(i_protected))
    else $error("program started without its conditions");
  page_keep_a: assert property (q.awr |-> q.aa[23:8] == q.pst[23:8])
    else $error("program left the addressed page");
  abort_wel_a: assert property (cs_rise && !q.ign && q.op == OP_PP &&
    q.st != S_OPC && !(q.st == S_PGM && pp_ok) |=> !q.write_enable_latch && q.pg == $past(q.pg))
    else $error("aborted program kept the latch");
  busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("busy dropped early");
  wel_done_a: assert property ($fell(o_busy) |-> !o_wel)
    else $error("latch still set after program");
  push_room_a: assert property (q.pend && !cs_rise |-> u_fin.ready)
    else $error("fetched byte had no room");
  wrap_read_c: cover property (q.ard && wrap_on && (q.fa[7:0] & msk) == msk);
  cont_read_c: cover property (cs_fall && q.cont);
  prog_done_c: cover property ($fell(o_busy));
  discoverable_parameters_read_c: cover property (u_fout.ready && q.op == OP_DISCOVERABLE_PARAMETERS);
endmodule : fsq_flash_seq

/* File: verification/fsq_host_model.sv */
// host controller model: frames on chip select, serial clock and data pins
// assumes a 25 ns core clock; serial clock 200 ns, mode 0, idle low
`timescale 1ns/1ps
module fsq_host_model
  import fsq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [3:0] i_io,
  output logic            o_cs_n,
  output logic            o_sck,
  output logic [3:0]      o_io,
  output logic [3:0]      o_oe
);
  logic [7:0] rb [0:15];
  logic [3:0] s;
  logic [7:0] rop = OP_QWRD; // quad read opcode; the bench may pick the other one
  // ==========================================
  // bit level
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_io   = 4'h0;
    o_oe   = 4'h0;
  end
  // clock runs only inside frames; sample late so slow answers still land
  task automatic ck(input logic [3:0] v, input logic [3:0] oe);
    o_io = v;
    o_oe = oe;
    repeat (4) @(negedge i_clk);
    o_sck = 1'b1;
    repeat (4) @(negedge i_clk);
    s = i_io;
    o_sck = 1'b0;
  endtask : ck
  task automatic go();
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : go
  // gap after cs rise keeps commands apart
  task automatic stop();
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_oe   = 4'h0;
    repeat (8) @(negedge i_clk);
  endtask : stop
  // single line, msb first
  task automatic tx(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) ck({3'h0, v[7 - i]}, 4'h1);
  endtask : tx
  task automatic rx1(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      ck(4'h0, 4'h0);
      v = {v[6:0], s[1]};
    end
  endtask : rx1
  function automatic logic [7:0] pd(input int k);
    return 8'(k) ^ (k > 255 ? 8'h40 : 8'h00);
  endfunction : pd
  // ==========================================
  // frames
  task automatic wrap_set(input logic [7:0] w);
    go();
    tx(OP_WRAP, 8);
    repeat (3) tx(8'h00, 8);
    tx(w, 8);
    stop();
  endtask : wrap_set
  task automatic rd_e7(input logic [23:0] a, input logic [7:0] m, input logic skip, input int n);
    go();
    if (!skip) tx(rop, 8);
    for (int i = 5; i >= 0; i--) ck(a[4 * i +: 4], 4'hF);
    ck(m[7:4], 4'hF);
    ck(m[3:0], 4'hF);
    repeat (rop == OP_QWRD ? 2 : 4) ck(4'h0, 4'h0);
    for (int i = 0; i < n; i++) begin
      ck(4'h0, 4'h0);
      rb[i][7:4] = s;
      ck(4'h0, 4'h0);
      rb[i][3:0] = s;
    end
    stop();
  endtask : rd_e7
  task automatic discoverable_parameters(input int n);
    go();
    tx(OP_DISCOVERABLE_PARAMETERS, 8);
    repeat (3) tx(8'h00, 8);
    repeat (8) ck(4'h0, 4'h0);
    for (int i = 0; i < n; i++) rx1(rb[i]);
    stop();
  endtask : discoverable_parameters
  task automatic status(output logic [7:0] v);
    go();
    tx(OP_RDSR, 8);
    rx1(v);
    stop();
  endtask : status
  task automatic wren();
    go();
    tx(OP_WREN, 8);
    stop();
  endtask : wren
  // ab address bits, n data bytes, xb stray bits before cs rise
  task automatic prog(input logic [23:0] a, input int n, input int xb, input int ab);
    go();
    tx(OP_PP, 8);
    for (int i = 0; i < ab; i++) ck({3'h0, a[23 - i]}, 4'h1);
    for (int k = 0; k < n; k++) tx(pd(k), 8);
    tx(8'hFF, xb);
    stop();
  endtask : prog
  // all ones on every line also reads as a mode byte other than 10
  task automatic crm();
    go();
    repeat (8) ck(4'hF, 4'hF);
    stop();
  endtask : crm
endmodule : fsq_host_model

/* File: verification/tb_top.sv */
// self-checking bench for the flash command sequencer
// assumes fsq_host_model drives the pins; a local array model answers
`timescale 1ns/1ps
module tb_top;
  import fsq_pkg::*;
  typedef struct packed {
    logic [7:0]  w;
    logic [23:0] a;
    logic [2:0]  ws;
  } fsq_row_t;
  localparam int LIMIT = 60000;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_protected = 1'b0;
  logic        i_qe_load = 1'b0, i_qe_value = 1'b1, tgl = 1'b0, oe_seen = 1'b0;
  fsq_byte_t   arr_rdata = 8'h00;
  logic        cs_n, sck, o_arr_rd, o_arr_wr, o_busy, o_wel, o_qe, o_cm;
  logic [3:0]  h_io, h_oe, io_w, o_io, o_io_oe;
  fsq_addr_t   o_arr_addr;
  fsq_byte_t   o_arr_wdata, b;
  logic [2:0]  o_ws;
  logic [31:0] wq [$];
  int          err_count = 0, num_checks = 0, cyc = 0;
  fsq_row_t    rows [0:5] = '{'{8'h10, 24'h00_01F8, 3'h1}, '{8'h00, 24'h00_0106, 3'h0},
    '{8'h20, 24'h00_021C, 3'h2}, '{8'h40, 24'h00_033E, 3'h4},
    '{8'h60, 24'h00_04FE, 3'h6}, '{8'h70, 24'h00_05FE, 3'h7}};
  always #12.5 i_clk = ~i_clk;
  // released lines toggle so a stale level never passes for data
  always_comb begin
    for (int k = 0; k < 4; k++) io_w[k] = o_io_oe[k] ? o_io[k] : (h_oe[k] ? h_io[k] : tgl);
  end
  fsq_flash_seq #(.P_PROG_CYCLES(16)) fsq_flash_seq_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sck(sck), .i_io(io_w),
    .i_protected(i_protected), .i_qe_load(i_qe_load), .i_qe_value(i_qe_value),
    .i_arr_rdata(arr_rdata), .o_io(o_io), .o_io_oe(o_io_oe), .o_arr_addr(o_arr_addr),
    .o_arr_rd(o_arr_rd), .o_arr_wr(o_arr_wr), .o_arr_wdata(o_arr_wdata), .o_busy(o_busy),
    .o_wel(o_wel), .o_quad_enable(o_qe), .o_wrap_setting(o_ws), .o_cont_mode(o_cm));
  fsq_host_model fsq_host_model_i (
    .i_clk(i_clk), .i_io(io_w), .o_cs_n(cs_n), .o_sck(sck), .o_io(h_io), .o_oe(h_oe));
  function automatic fsq_byte_t av(input fsq_addr_t a);
    return a[7:0] ^ a[15:8] ^ 8'hC3;
  endfunction : av
  // expected fetch address: linear, or looping inside the aligned section
  function automatic fsq_addr_t ea(input logic [2:0] ws, input fsq_addr_t a, input int i);
    fsq_addr_t m;
    m = (24'h00_0008 << ws[2:1]) - 24'h00_0001;
    return ws[0] ? a + 24'(i) : (a & ~m) | ((a + 24'(i)) & m);
  endfunction : ea
  // array model: data valid the cycle after a fetch; writes logged
  always @(negedge i_clk) begin
    if (o_arr_rd === 1'b1) arr_rdata <= av(o_arr_addr);
  end
  always @(posedge i_clk) begin
    tgl <= ~tgl;
    if (o_arr_wr === 1'b1) wq.push_back({o_arr_addr, o_arr_wdata});
    if (o_io_oe !== 4'h0) oe_seen <= 1'b1;
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask : tdone
  task automatic qe_ld(input logic v);
    i_qe_value = v;
    i_qe_load  = 1'b1;
    @(negedge i_clk);
    i_qe_load  = 1'b0;
    @(negedge i_clk);
  endtask : qe_ld
  task automatic wait_done();
    b = 8'hFF;
    for (int i = 0; i < 20 && b[0] !== 1'b0; i++) fsq_host_model_i.status(b);
    chk(b[0] === 1'b0 && o_busy === 1'b0, "busy stuck");
    chk(o_wel === 1'b0, "latch kept after program");
  endtask : wait_done
  task automatic chk_prog(input fsq_addr_t a, input int n);
    int o;
    chk(wq.size() == (n > 256 ? 256 : n), "write count");
    foreach (wq[j]) begin
      o = 8'(wq[j][15:8] - a[7:0]);
      chk(wq[j][31:16] === a[23:8], "left the page");
      chk(wq[j][7:0] === fsq_host_model_i.pd(o + 256 * ((n - 1 - o) / 256)), "data");
    end
  endtask : chk_prog
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    chk(o_ws === 3'h1, "wrap reset");
    chk(o_qe === 1'b1, "quad enable reset");
    chk({o_wel, o_busy, o_cm} === 3'h0, "flags reset");
    tdone("reset");
    foreach (rows[r]) begin
      fsq_host_model_i.rop = (r == 3) ? OP_QRD : OP_QWRD;
      fsq_host_model_i.wrap_set(rows[r].w);
      chk(o_ws === rows[r].ws, "wrap bits");
      fsq_host_model_i.rd_e7(rows[r].a, 8'h00, 1'b0, 10);
      for (int i = 0; i < 10; i++)
        chk(fsq_host_model_i.rb[i] === av(ea(rows[r].ws, rows[r].a, i)), "read");
    end
    tdone("wrap rows");
    fsq_host_model_i.rd_e7(24'h00_0010, 8'h20, 1'b0, 4);
    chk(o_cm === 1'b1, "continuous not armed");
    fsq_host_model_i.rd_e7(24'h00_0020, 8'h00, 1'b1, 4);
    for (int i = 0; i < 4; i++)
      chk(fsq_host_model_i.rb[i] === av(24'h00_0020 + 24'(i)), "no-opcode read");
    chk(o_cm === 1'b0, "continuous kept");
    fsq_host_model_i.rd_e7(24'h00_0010, 8'h20, 1'b0, 1);
    fsq_host_model_i.crm();
    chk(o_cm === 1'b0, "continuous reset");
    tdone("continuous");
    qe_ld(1'b0);
    chk(o_qe === 1'b0, "quad enable load");
    oe_seen = 1'b0;
    fsq_host_model_i.rd_e7(24'h00_0040, 8'h00, 1'b0, 2);
    chk(oe_seen === 1'b0, "read without quad enable");
    qe_ld(1'b1);
    tdone("quad enable");
    fsq_host_model_i.wrap_set(8'h00);
    fsq_host_model_i.discoverable_parameters(9);
    for (int i = 0; i < 9; i++)
      chk(fsq_host_model_i.rb[i] === (i < 8 ? DISCOVERABLE_PARAMETERS_TBL[63 - 8 * i -: 8] : ERASED), "table");
    tdone("table");
    wq.delete();
    fsq_host_model_i.prog(24'h00_00FE, 1, 0, 24);
    chk(wq.size() == 0 && o_busy === 1'b0, "program without latch");
    fsq_host_model_i.wren();
    chk(o_wel === 1'b1, "latch not set");
    fsq_host_model_i.prog(24'h00_00FE, 3, 0, 24);
    chk(o_busy === 1'b1, "not busy");
    fsq_host_model_i.status(b);
    chk(b[0] === 1'b1, "status not busy");
    wait_done();
    chk_prog(24'h00_00FE, 3);
    tdone("page wrap program");
    for (int c = 0; c < 4; c++) begin
      fsq_host_model_i.wren();
      i_protected = (c == 3);
      wq.delete();
      fsq_host_model_i.prog(24'h00_0500, c % 2, c == 0 ? 4 : (c == 1 ? 3 : 0),
        c == 2 ? 16 : 24);
      repeat (8) @(negedge i_clk);
      chk(wq.size() == 0 && o_busy === 1'b0 && o_wel === 1'b0, "abort");
    end
    i_protected = 1'b0;
    tdone("aborts");
    fsq_host_model_i.wren();
    wq.delete();
    fsq_host_model_i.prog(24'h00_0300, 258, 0, 24);
    wait_done();
    chk_prog(24'h00_0300, 258);
    tdone("overlong program");
    final_report();
  end
endmodule : tb_top
